// ### core/cbp_block_protocol.sv
// Half-duplex block transmission layer of a proximity tag: block numbering, replies to
// I-, R- and S-blocks, chaining, retransmission and error answers.
// Assumes a framing layer delivering checked bytes and an application that answers commands.
`default_nettype none

// Overview of operation
// - Tag block number becomes one on activation.
// - Tag toggles number on every received I-block.
// - Toggle on differing ACK only while the tag chains; never on NAK.
// - Tag transmits only after receiving a block.
// - Chained I-block is acknowledged with R(ACK).
// - Every DESELECT request gets a DESELECT reply.
// - Illegal block or timeout gets R(NAK).
// - While chaining, errors get R(ACK) instead.
// - Tag never sends a waiting time extension.
// - Unchained I-block gets an affirmative I-block reply.
// - Matching ACK or NAK resends last I-block.
// - Differing NAK is answered with R(ACK).
// - Differing ACK while chaining sends next chunk.
// - Command units travel inside the information field.
// - Response is data then two status bytes.
// - Identifier and node address bytes are refused.
// - Chained frames must be at least 64 bytes; only received chained I-blocks are checked, tag chained blocks are not.
// - Data field is at most 256 bytes.
module cbp_block_protocol
    import cbp_pkg::*;
(
    input  wire logic       CORE_CLK_I,    // Core clock, 10 MHz.
    input  wire logic       RESET_N_I,     // Asynchronous reset, active low.
    input  wire logic       ACTIVATE_I,    // Tag activation pulse.
    input  wire logic       FWT_TIMEOUT_I, // Frame waiting time expired pulse.
    input  wire logic       RX_VALID_I,    // Received byte strobe.
    input  wire logic [7:0] RX_DATA_I,     // Received byte.
    input  wire logic       RX_LAST_I,     // Last byte of the frame.
    input  wire logic       RX_ERR_I,      // Frame error, valid with the last byte.
    input  wire logic       TX_READY_I,    // Framer takes the current transmit byte.
    output logic            TX_VALID_O,    // Transmit byte valid.
    output logic      [7:0] TX_DATA_O,     // Transmit byte.
    output logic            TX_LAST_O,     // Last byte of the transmit frame.
    output logic            CMD_VALID_O,   // Command information byte strobe.
    output logic      [7:0] CMD_DATA_O,    // Command information byte.
    output logic            CMD_END_O,     // End of a received I-block.
    output logic            CMD_ERR_O,     // Received I-block was illegal, with end.
    output logic            CMD_CHAIN_O,   // Received I-block is chained, with end.
    input  wire logic       RSP_VALID_I,   // Response byte strobe.
    input  wire logic [7:0] RSP_DATA_I,    // Response byte.
    input  wire logic       RSP_LAST_I,    // Last response byte of this block.
    input  wire logic       RSP_MORE_I,    // More response blocks follow, with last.
    output logic            RSP_READY_O,   // Response bytes are accepted.
    output logic            RSP_NEXT_O,    // Request for the next response block.
    output logic            DESELECT_O     // Tag was deselected.
);

    typedef struct packed {
        cbp_state_e_t state;
        logic         bn;
        logic         rx_chain;
        logic         tx_chain;
        logic         rx_seen;
        logic [8:0]   rx_cnt;
        logic [7:0]   pcb;
        logic [7:0]   last_i_pcb;
        logic [7:0]   tx_len;
        logic [7:0]   tx_idx;
        logic         tx_inf;
        logic         tx_pcb_phase;
        logic [7:0]   wr_ptr;
        logic         tx_valid;
        logic [7:0]   tx_data;
        logic         tx_last;
        logic         cmd_valid;
        logic [7:0]   cmd_data;
        logic         cmd_end;
        logic         cmd_err;
        logic         cmd_chain;
        logic         rsp_ready;
        logic         rsp_next;
        logic         deselect;
    } cbp_regs_t;

    localparam cbp_regs_t REGS_RESET = '{state: ST_IDLE, bn: BN_INIT, default: '0};

    cbp_regs_t  st_reg;
    cbp_regs_t  st_next;
    logic [7:0] rd_data;
    logic       buf_we;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame decoding.

    logic       rx_first;
    logic [7:0] pcb_f;
    logic [8:0] total;
    logic       rx_end;
    logic       blk_i;
    logic       blk_r;
    logic       blk_d;
    logic       rx_bad;
    logic       same_num;
    logic       chaining;
    logic       ev_i_chain;
    logic       ev_i_last;
    logic       ev_rack_diff;
    logic       ev_r_same;
    logic       ev_rnak_diff;
    logic       ev_desel;
    logic       ev_err;

    assign rx_first = (st_reg.rx_cnt == '0);
    assign pcb_f    = rx_first ? RX_DATA_I : st_reg.pcb;
    assign total    = st_reg.rx_cnt + 9'h001;
    assign rx_end   = (st_reg.state == ST_IDLE) && RX_VALID_I && RX_LAST_I && !ACTIVATE_I;
    assign same_num = (pcb_f[PCB_NUM_BIT] == st_reg.bn);
    assign chaining = st_reg.rx_chain || st_reg.tx_chain;
    assign blk_i    = ((pcb_f & PCB_I_MASK) == PCB_I_VAL)
                      && !pcb_f[PCB_CID_BIT] && !pcb_f[PCB_NAD_BIT];
    assign blk_r    = ((pcb_f & PCB_R_MASK) == PCB_R_VAL) && !pcb_f[PCB_CID_BIT] && (total == 9'h001);
    assign blk_d    = (pcb_f == PCB_DESELECT) && (total == 9'h001);
    // Anything but DESELECT in an S-block, including a waiting time extension, is refused.
    assign rx_bad   = RX_ERR_I
                      || (total > MAX_BLOCK_BYTES)
                      || !(blk_i || blk_r || blk_d)
                      || (blk_i && pcb_f[PCB_CHAIN_BIT] && (total + CRC_BYTES < CHAIN_MIN_BYTES))
                      || (blk_r && !pcb_f[PCB_NAK_BIT] && !same_num && !st_reg.tx_chain);

    assign ev_i_chain   = rx_end && !rx_bad && blk_i && pcb_f[PCB_CHAIN_BIT];
    assign ev_i_last    = rx_end && !rx_bad && blk_i && !pcb_f[PCB_CHAIN_BIT];
    assign ev_rack_diff = rx_end && !rx_bad && blk_r && !pcb_f[PCB_NAK_BIT] && !same_num;
    assign ev_r_same    = rx_end && !rx_bad && blk_r && same_num;
    assign ev_rnak_diff = rx_end && !rx_bad && blk_r && pcb_f[PCB_NAK_BIT] && !same_num;
    assign ev_desel     = rx_end && !rx_bad && blk_d;
    assign ev_err       = (rx_end && rx_bad)
                          || ((st_reg.state == ST_IDLE) && !ACTIVATE_I && !RX_VALID_I
                              && FWT_TIMEOUT_I && st_reg.rx_seen && rx_first);

    function automatic logic [7:0] f_pcb(input logic [7:0] base, input logic bn);
        logic [7:0] p;
        p = base;
        p[PCB_NUM_BIT] = bn;
        return p;
    endfunction : f_pcb

    // Starts a transmit frame; the control byte goes out first.
    function automatic cbp_regs_t f_start(input cbp_regs_t s, input logic [7:0] pcb, input logic inf);
        cbp_regs_t r;
        r = s;
        r.state        = ST_TX;
        r.tx_valid     = 1'b1;
        r.tx_data      = pcb;
        r.tx_inf       = inf;
        r.tx_last      = !(inf && (s.tx_len != '0));
        r.tx_idx       = '0;
        r.tx_pcb_phase = 1'b1;
        return r;
    endfunction : f_start

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb
    begin
        st_next           = st_reg;
        st_next.cmd_valid = 1'b0;
        st_next.cmd_end   = 1'b0;
        st_next.rsp_next  = 1'b0;
        st_next.deselect  = 1'b0;
        if (ACTIVATE_I)
        begin
            st_next = REGS_RESET;
        end
        else
        begin
            unique case (st_reg.state)
                ST_IDLE:
                begin
                    if (RX_VALID_I)
                    begin
                        st_next.rx_seen = 1'b1;
                        if (rx_first)
                        begin
                            st_next.pcb = RX_DATA_I;
                        end
                        else if ((st_reg.pcb & PCB_I_MASK) == PCB_I_VAL)
                        begin
                            st_next.cmd_valid = 1'b1;
                            st_next.cmd_data  = RX_DATA_I;
                        end
                        if (RX_LAST_I)
                        begin
                            st_next.rx_cnt = '0;
                        end
                        else if (st_reg.rx_cnt != RX_CNT_MAX)
                        begin
                            st_next.rx_cnt = st_reg.rx_cnt + 9'h001;
                        end
                        if (RX_LAST_I && ((pcb_f & PCB_I_MASK) == PCB_I_VAL))
                        begin
                            st_next.cmd_end   = 1'b1;
                            st_next.cmd_err   = rx_bad;
                            st_next.cmd_chain = pcb_f[PCB_CHAIN_BIT];
                        end
                    end
                    if (ev_i_chain)
                    begin
                        st_next.bn       = !st_reg.bn;
                        st_next.rx_chain = 1'b1;
                        st_next.tx_chain = 1'b0;
                        st_next          = f_start(st_next, f_pcb(PCB_ACK_BASE, !st_reg.bn), 1'b0);
                    end
                    else if (ev_i_last)
                    begin
                        st_next.bn        = !st_reg.bn;
                        st_next.rx_chain  = 1'b0;
                        st_next.tx_chain  = 1'b0;
                        st_next.state     = ST_WAIT_RSP;
                        st_next.wr_ptr    = '0;
                        st_next.rsp_ready = 1'b1;
                    end
                    else if (ev_rack_diff)
                    begin
                        st_next.bn        = !st_reg.bn;
                        st_next.state     = ST_WAIT_RSP;
                        st_next.wr_ptr    = '0;
                        st_next.rsp_ready = 1'b1;
                        st_next.rsp_next  = 1'b1;
                    end
                    else if (ev_r_same)
                    begin
                        st_next = f_start(st_next, st_reg.last_i_pcb, 1'b1);
                    end
                    else if (ev_rnak_diff)
                    begin
                        st_next = f_start(st_next, f_pcb(PCB_ACK_BASE, st_reg.bn), 1'b0);
                    end
                    else if (ev_desel)
                    begin
                        st_next.rx_chain = 1'b0;
                        st_next.tx_chain = 1'b0;
                        st_next.deselect = 1'b1;
                        st_next          = f_start(st_next, PCB_DESELECT, 1'b0);
                    end
                    else if (ev_err)
                    begin
                        st_next = f_start(st_next, f_pcb(chaining ? PCB_ACK_BASE : PCB_NAK_BASE, st_reg.bn),
                                          1'b0);
                    end
                end
                ST_WAIT_RSP:
                begin
                    if (RSP_VALID_I)
                    begin
                        // Bytes beyond one frame's information field are dropped.
                        if (st_reg.wr_ptr != MAX_INF_BYTES)
                        begin
                            st_next.wr_ptr = st_reg.wr_ptr + 8'h01;
                        end
                        if (RSP_LAST_I)
                        begin
                            st_next.rsp_ready  = 1'b0;
                            st_next.tx_chain   = RSP_MORE_I;
                            st_next.tx_len     = st_next.wr_ptr;
                            st_next.last_i_pcb = f_pcb(PCB_I_BASE, st_reg.bn);
                            st_next.last_i_pcb[PCB_CHAIN_BIT] = RSP_MORE_I;
                            st_next = f_start(st_next, st_next.last_i_pcb, 1'b1);
                        end
                    end
                end
                ST_TX:
                begin
                    if (TX_READY_I)
                    begin
                        st_next.tx_pcb_phase = 1'b0;
                        if (st_reg.tx_last)
                        begin
                            st_next.tx_valid = 1'b0;
                            st_next.tx_last  = 1'b0;
                            st_next.state    = ST_IDLE;
                        end
                        else
                        begin
                            st_next.tx_data = rd_data;
                            st_next.tx_last = (st_reg.tx_idx == st_reg.tx_len - 8'h01);
                            st_next.tx_idx  = st_reg.tx_idx + 8'h01;
                        end
                    end
                end
                default:
                begin
                    st_next = REGS_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            st_reg <= REGS_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign buf_we = (st_reg.state == ST_WAIT_RSP) && RSP_VALID_I && !ACTIVATE_I
                    && (st_reg.wr_ptr != MAX_INF_BYTES);

    cbp_retx_buf u_retx_buf (
        .clk_i     (CORE_CLK_I),
        .wr_en_i   (buf_we),
        .wr_addr_i (st_reg.wr_ptr),
        .wr_data_i (RSP_DATA_I),
        .rd_addr_i (st_reg.tx_idx),
        .rd_data_o (rd_data)
    );

    assign TX_VALID_O  = st_reg.tx_valid;
    assign TX_DATA_O   = st_reg.tx_data;
    assign TX_LAST_O   = st_reg.tx_last;
    assign CMD_VALID_O = st_reg.cmd_valid;
    assign CMD_DATA_O  = st_reg.cmd_data;
    assign CMD_END_O   = st_reg.cmd_end;
    assign CMD_ERR_O   = st_reg.cmd_err;
    assign CMD_CHAIN_O = st_reg.cmd_chain;
    assign RSP_READY_O = st_reg.rsp_ready;
    assign RSP_NEXT_O  = st_reg.rsp_next;
    assign DESELECT_O  = st_reg.deselect;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence s_reply(logic [3:0] kind);
        TX_VALID_O && st_reg.tx_pcb_phase && (TX_DATA_O[7:4] == kind);
    endsequence

    sequence s_no_activate;
        !ACTIVATE_I;
    endsequence

    property p_activate_bn;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I) ACTIVATE_I |=> (st_reg.bn == BN_INIT) && !TX_VALID_O;
    endproperty
    a_activate_bn: assert property (p_activate_bn) else $error("Block number not one after activation.");

    property p_i_toggle;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I) (ev_i_chain || ev_i_last) |=> (st_reg.bn != $past(st_reg.bn));
    endproperty
    a_i_toggle: assert property (p_i_toggle) else $error("Block number kept on I-block.");

    property p_nak_keep;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
            (rx_end && !rx_bad && blk_r && pcb_f[PCB_NAK_BIT]) |=> $stable(st_reg.bn);
    endproperty
    a_nak_keep: assert property (p_nak_keep) else $error("Block number changed on R(NAK).");

    property p_silent_first;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I) !st_reg.rx_seen |-> !TX_VALID_O;
    endproperty
    a_silent_first: assert property (p_silent_first) else $error("Transmit before any block received.");

    property p_chain_ack;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
            ev_i_chain |=> s_reply(PCB_ACK_TYPE) ##0 (TX_DATA_O[PCB_NUM_BIT] == st_reg.bn);
    endproperty
    a_chain_ack: assert property (p_chain_ack) else $error("Chained I-block not acknowledged.");

    property p_deselect;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I) ev_desel |=> TX_VALID_O && (TX_DATA_O == PCB_DESELECT) && DESELECT_O;
    endproperty
    a_deselect: assert property (p_deselect) else $error("DESELECT not answered.");

    property p_err_nak;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I) (ev_err && !chaining) |=> s_reply(PCB_NAK_TYPE);
    endproperty
    a_err_nak: assert property (p_err_nak) else $error("Error outside chaining not answered with R(NAK).");

    property p_err_ack;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I) (ev_err && chaining) |=> s_reply(PCB_ACK_TYPE);
    endproperty
    a_err_ack: assert property (p_err_ack) else $error("Error while chaining not answered with R(ACK).");

    property p_no_wtx;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I) (TX_VALID_O && st_reg.tx_pcb_phase) |-> (TX_DATA_O != PCB_WTX);
    endproperty
    a_no_wtx: assert property (p_no_wtx) else $error("Waiting time extension sent.");

    // Covers the first block of a reply and every later block of a tag chain alike.
    property p_i_answer;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
            ((st_reg.state == ST_WAIT_RSP) && RSP_VALID_I && RSP_LAST_I && !ACTIVATE_I)
            |=> TX_VALID_O && ((TX_DATA_O & PCB_I_MASK) == PCB_I_VAL) && (TX_DATA_O[PCB_NUM_BIT] == st_reg.bn);
    endproperty
    a_i_answer: assert property (p_i_answer) else $error("Unchained I-block not answered with an I-block.");

    property p_retransmit;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I) ev_r_same |=> TX_VALID_O && (TX_DATA_O == $past(st_reg.last_i_pcb));
    endproperty
    a_retransmit: assert property (p_retransmit) else $error("Last I-block not resent.");

    property p_nak_diff;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I) ev_rnak_diff |=> s_reply(PCB_ACK_TYPE);
    endproperty
    a_nak_diff: assert property (p_nak_diff) else $error("Differing R(NAK) not answered with R(ACK).");

    property p_chain_next;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
            (ev_rack_diff && st_reg.tx_chain) ##0 s_no_activate |=> RSP_NEXT_O && RSP_READY_O;
    endproperty
    a_chain_next: assert property (p_chain_next) else $error("Next chained block not requested.");

endmodule : cbp_block_protocol

`default_nettype wire

// ### core/cbp_pkg.sv
// Constants shared by the contactless block protocol layer: block control byte codes,
// field positions, frame size limits and the state encoding.
// Assumes a byte-wide framing layer that strips start, end and CRC bytes.
`default_nettype none

package cbp_pkg;

    // Block control byte patterns and fixed codes.
    localparam logic [7:0] PCB_I_MASK   = 8'hE2;
    localparam logic [7:0] PCB_I_VAL    = 8'h02;
    localparam logic [7:0] PCB_R_MASK   = 8'hE6;
    localparam logic [7:0] PCB_R_VAL    = 8'hA2;
    localparam logic [7:0] PCB_I_BASE   = 8'h02;
    localparam logic [7:0] PCB_ACK_BASE = 8'hA2;
    localparam logic [7:0] PCB_NAK_BASE = 8'hB2;
    localparam logic [7:0] PCB_DESELECT = 8'hC2;
    localparam logic [7:0] PCB_WTX      = 8'hF2;
    localparam logic [3:0] PCB_ACK_TYPE = 4'hA;
    localparam logic [3:0] PCB_NAK_TYPE = 4'hB;

    // Field positions inside the control byte.
    localparam int PCB_NUM_BIT   = 0;
    localparam int PCB_NAD_BIT   = 2;
    localparam int PCB_CID_BIT   = 3;
    localparam int PCB_CHAIN_BIT = 4;
    localparam int PCB_NAK_BIT   = 4;

    // Block number after activation.
    localparam logic BN_INIT = 1'b1;

    // Frame size limits in bytes.
    localparam logic [8:0] CRC_BYTES       = 9'h002;
    localparam logic [8:0] MAX_FIELD_BYTES = 9'h100;
    localparam logic [8:0] CHAIN_MIN_BYTES = 9'h040;
    localparam logic [8:0] MAX_BLOCK_BYTES = MAX_FIELD_BYTES - CRC_BYTES;
    localparam logic [7:0] MAX_INF_BYTES   = 8'hFD;
    localparam logic [8:0] RX_CNT_MAX      = 9'h1FF;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b001,
        ST_WAIT_RSP = 3'b010,
        ST_TX       = 3'b100
    } cbp_state_e_t;

endpackage : cbp_pkg

`default_nettype wire

// ### core/cbp_retx_buf.sv
// Byte store holding the information field of the last I-block sent by the tag.
// Assumes one writer and one reader on the same clock; the read is combinational.
`default_nettype none

module cbp_retx_buf
    import cbp_pkg::*;
(
    input  wire logic       clk_i,     // Core clock.
    input  wire logic       wr_en_i,   // Write strobe.
    input  wire logic [7:0] wr_addr_i, // Write address.
    input  wire logic [7:0] wr_data_i, // Write data.
    input  wire logic [7:0] rd_addr_i, // Read address.
    output logic      [7:0] rd_data_o  // Read data.
);

    // The store keeps no reset: only bytes written after a response are ever read.
    logic [7:0] mem [0:255];

    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    assign rd_data_o = mem[rd_addr_i];

endmodule : cbp_retx_buf

`default_nettype wire

// ### verification/cbp_reader_model.sv
// Reader side model: sends frames into the tag and collects its reply bytes.
// Assumes one core clock; it stalls the transmit handshake on every other cycle.
`default_nettype none

module cbp_reader_model
(
    input  wire logic       clk_i,      // Core clock.
    input  wire logic       tx_valid_i, // Tag byte valid.
    input  wire logic [7:0] tx_data_i,  // Tag byte.
    input  wire logic       tx_last_i,  // Last tag byte.
    output logic            tx_ready_o, // Byte taken.
    output logic            rx_valid_o, // Reader byte strobe.
    output logic      [7:0] rx_data_o,  // Reader byte.
    output logic            rx_last_o,  // Last reader byte.
    output logic            rx_err_o    // Frame error.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    int         frames = 0;
    logic       bn = 1'b0;
    initial {tx_ready_o, rx_valid_o, rx_data_o, rx_last_o, rx_err_o} = '0;
    // Half-rate ready proves the tag holds each byte until it is taken.
    always @(posedge clk_i)
    begin
        tx_ready_o <= ~tx_ready_o;
        if (tx_valid_i && tx_ready_o)
        begin
            got.push_back(tx_data_i);
            if (tx_last_i)
            begin
                frames++;
                if ((got[0][7:6] == 2'b00 || got[0][7:4] == 4'hA) && got[0][0] == bn)
                    bn <= ~bn;
            end
        end
    end
    // The reader always opens an exchange. The released data line shows the inverse of the last byte.
    task automatic send(input logic [7:0] b[$], input logic err);
        foreach (b[i])
        begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o  <= b[i];
            rx_last_o  <= (i == b.size() - 1);
            rx_err_o   <= err && (i == b.size() - 1);
        end
        @(posedge clk_i);
        {rx_valid_o, rx_last_o, rx_err_o} <= '0;
        rx_data_o <= ~rx_data_o;
    endtask : send
endmodule : cbp_reader_model

`default_nettype wire

// ### verification/cbp_tb.sv
// Bench for the block protocol layer: scenarios drive the reader model and the response side.
// Assumes the reader model above; the bench pulses the frame waiting timeout itself.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import cbp_pkg::*;
    logic clk = 0, rst_n = 0, act = 0, rv = 0, rl = 0, rm = 0, fwt = 0, desel = 0, nxt = 0;
    logic [1:0] cmd_fl = '0;
    logic [7:0] rd = '0, ncmd = '0, csum = '0;
    logic tv, tl, tr, xv, xl, xe;
    logic [7:0] td, xd;
    int fails = 0, compares = 0, nexp = 0;
    always #50 clk = ~clk;
    // Output pulses are caught here so that the scenarios can judge them after the frame.
    always @(posedge clk)
    begin
        if (i_dut.DESELECT_O === 1'b1) desel <= 1'b1;
        if (i_dut.RSP_NEXT_O === 1'b1) nxt <= 1'b1;
        if (i_dut.CMD_VALID_O === 1'b1) {ncmd, csum} <= {ncmd + 8'h01, csum ^ i_dut.CMD_DATA_O};
        if (i_dut.CMD_END_O === 1'b1) cmd_fl <= {i_dut.CMD_ERR_O, i_dut.CMD_CHAIN_O};
    end
    cbp_reader_model i_rdr (.clk_i(clk), .tx_valid_i(tv), .tx_data_i(td), .tx_last_i(tl), .tx_ready_o(tr),
        .rx_valid_o(xv), .rx_data_o(xd), .rx_last_o(xl), .rx_err_o(xe));
    cbp_block_protocol i_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .ACTIVATE_I(act), .FWT_TIMEOUT_I(fwt),
        .RX_VALID_I(xv), .RX_DATA_I(xd), .RX_LAST_I(xl), .RX_ERR_I(xe), .TX_READY_I(tr), .TX_VALID_O(tv),
        .TX_DATA_O(td), .TX_LAST_O(tl), .CMD_VALID_O(), .CMD_DATA_O(), .CMD_END_O(), .CMD_ERR_O(),
        .CMD_CHAIN_O(), .RSP_VALID_I(rv), .RSP_DATA_I(rd), .RSP_LAST_I(rl), .RSP_MORE_I(rm),
        .RSP_READY_O(), .RSP_NEXT_O(), .DESELECT_O());
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : check
    // Waits for one more tag frame and compares it byte by byte.
    task automatic reply(input logic [7:0] e[$]);
        nexp++;
        for (int i = 0; i < 400 && i_rdr.frames < nexp; i++) @(posedge clk);
        if (i_rdr.frames < nexp)
        begin
            fails++;
            final_report();
        end
        check("reply length", 8'(i_rdr.got.size()), 8'(e.size()));
        foreach (e[i]) check("reply byte", i_rdr.got[i], e[i]);
        i_rdr.got.delete();
    endtask : reply
    task automatic answer(input logic more);
        for (int i = 0; i < 50 && i_dut.RSP_READY_O !== 1'b1; i++) @(posedge clk);
        if (i_dut.RSP_READY_O !== 1'b1)
        begin
            fails++;
            final_report();
        end
        @(posedge clk);
        rv <= 1'b1;
        rd <= 8'h90;
        @(posedge clk);
        {rd, rl, rm} <= {8'h00, 1'b1, more};
        @(posedge clk);
        {rv, rl, rm} <= '0;
    endtask : answer
    ////////////////////////////////////////////////////////////////////////////////
    // Unchained select-style command without Lc or Le, then retransmit and error answers.
    task automatic sc_exchange;
        i_rdr.send('{8'h02, 8'h00, 8'hA4, 8'h04, 8'h00}, 1'b0);
        answer(1'b0);
        reply('{8'h02, 8'h90, 8'h00});
        check("cmd bytes", ncmd, 8'h04);
        check("cmd xor", csum, 8'hA0);
        check("next req", 8'(nxt), 8'h00);
        i_rdr.send('{8'hB2}, 1'b0);
        reply('{8'h02, 8'h90, 8'h00});
        i_rdr.send('{8'hB3}, 1'b0);
        reply('{8'hA2});
        i_rdr.send('{8'h03, 8'h00}, 1'b1);
        reply('{8'hB2});
        check("cmd flags", 8'(cmd_fl), 8'h02);
        i_rdr.send('{8'h0B, 8'h00}, 1'b0);
        reply('{8'hB2});
        fwt <= 1'b1;
        @(posedge clk);
        fwt <= 1'b0;
        reply('{8'hB2});
    endtask : sc_exchange
    // Chained block of exactly 64 counted bytes, a timeout and a resend in the chain, a tag chain, then deselect.
    task automatic sc_chain_deselect;
        logic [7:0] q[$];
        q = '{8'h12 | 8'(i_rdr.bn)};
        repeat (61) q.push_back(8'h00);
        i_rdr.send(q, 1'b0);
        reply('{8'hA3});
        check("cmd flags", 8'(cmd_fl), 8'h01);
        fwt <= 1'b1;
        @(posedge clk);
        fwt <= 1'b0;
        reply('{8'hA3});
        i_rdr.send(q, 1'b0);
        reply('{8'hA2});
        i_rdr.send('{8'h03, 8'h00, 8'hB0, 8'h00, 8'h00}, 1'b0);
        answer(1'b1);
        reply('{8'h13, 8'h90, 8'h00});
        i_rdr.send('{8'hA2}, 1'b0);
        answer(1'b0);
        reply('{8'h02, 8'h90, 8'h00});
        check("next req", 8'(nxt), 8'h01);
        i_rdr.send('{8'hC2}, 1'b0);
        reply('{8'hC2});
        check("deselect pulse", 8'(desel), 8'h01);
    endtask : sc_chain_deselect
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        act <= 1'b1;
        @(posedge clk);
        act <= 1'b0;
        sc_exchange();
        sc_chain_deselect();
        final_report();
    end
endmodule : testbench

`default_nettype wire
